// *** ecc_ctrl.sv ***
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "ecc_regs.svh"
module ecc_ctrl
  import ecc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // Control register port
  input wire logic [3:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  // Protected RAM writes
  input wire ecc_wr_t TAG_WR_IN,
  input wire logic TAG_VALID_IN,
  input wire logic LINE_INIT_IN,
  input wire ecc_wr_t DAT_WR_IN,
  input wire logic DAT_FIRST_IN,
  input wire ecc_wr_t TLB_WR_IN,
  input wire ecc_wr_t RF_WR_IN,
  input wire logic [4:0] RF_WR_IDX_IN,
  output ecc_wr_t TAG_WR_OUT,
  output logic TAG_VALID_OUT,
  output ecc_wr_t DAT_WR_OUT,
  output ecc_wr_t TLB_WR_OUT,
  output ecc_wr_t RF_WR_OUT,
  output logic MICRO_TRANSLATION_BUFFER_FLUSH_OUT,
  // Protected RAM read checks
  input wire ecc_rd_t TAG_RD_IN,
  input wire ecc_rd_t DAT_RD_IN,
  input wire logic LINE_VALID_IN,
  input wire ecc_rd_t TLB_RD_IN,
  input wire logic TLB_RD_SW_IN,
  input wire ecc_rd_t RF_RDA_IN,
  input wire ecc_rd_t RF_RDB_IN,
  input wire logic IN_HANDLER_IN,
  // Exceptions and events
  output logic TLB_SW_RD_OUT,
  output logic EXC_OUT,
  output logic [4:0] EXC_CAUSE_OUT,
  output ecc_event_t EVENT_OUT
);

  function automatic logic [`ECC_CHK_W-1:0] inj_mask(input ecc_inj_t code);
    case (code)
      INJECT_SINGLE_CODE: inj_mask = `ECC_MASK_SINGLE;
      INJECT_DOUBLE_CODE: inj_mask = `ECC_MASK_DOUBLE;
      default: inj_mask = '0;
    endcase
  endfunction

  function automatic logic armed(input ecc_inj_t code);
    armed = (code == INJECT_SINGLE_CODE) || (code == INJECT_DOUBLE_CODE);
  endfunction

  function automatic ecc_wr_t corrupt(input ecc_wr_t w, input logic hit, input ecc_inj_t code);
    corrupt = w;
    if (hit)
    begin
      corrupt.chk = w.chk ^ inj_mask(code);
    end
  endfunction

  logic check_enable_bit;
  ecc_inj_t tag_inj;
  ecc_inj_t dat_inj;
  ecc_inj_t tlb_inj;
  ecc_inj_t rf_inj;
  logic translation_error_flag;
  logic next_check_enable_bit;
  ecc_inj_t next_tag_inj;
  ecc_inj_t next_dat_inj;
  ecc_inj_t next_tlb_inj;
  ecc_inj_t next_rf_inj;
  logic next_translation_error_flag;
  logic [31:0] next_rdata;

  logic cfg_wr;
  logic inj_wr;
  logic misc_wr;
  logic tag_hit;
  logic dat_hit;
  logic tlb_hit;
  logic rf_hit;

  assign cfg_wr = REG_WR_IN && (REG_ADDR_IN == `ECC_CONFIG_OFF);
  assign inj_wr = REG_WR_IN && (REG_ADDR_IN == `ECC_INJ_OFF);
  assign misc_wr = REG_WR_IN && (REG_ADDR_IN == `ECC_TRANSLATION_MISC_CONTROL_OFF);
  // Injection points: fill start tag write, first data beat, entry write, non-zero register
  assign tag_hit = TAG_WR_IN.wr && !LINE_INIT_IN && armed(tag_inj);
  assign dat_hit = DAT_WR_IN.wr && DAT_FIRST_IN && armed(dat_inj);
  assign tlb_hit = TLB_WR_IN.wr && armed(tlb_inj);
  assign rf_hit = RF_WR_IN.wr && (RF_WR_IDX_IN != 5'h00) && armed(rf_inj);

  // Uncorrectable and corrected detections
  logic ic_dbl;
  logic tlb_hw_dbl;
  logic tlb_sw_dbl;
  logic rf_dbl;
  logic any_sgl;
  logic any_dbl;
  assign ic_dbl = LINE_VALID_IN && ((TAG_RD_IN.rd && TAG_RD_IN.dbl) || (DAT_RD_IN.rd && DAT_RD_IN.dbl));
  assign tlb_hw_dbl = TLB_RD_IN.rd && TLB_RD_IN.dbl && !TLB_RD_SW_IN;
  assign tlb_sw_dbl = TLB_RD_IN.rd && TLB_RD_IN.dbl && TLB_RD_SW_IN;
  assign rf_dbl = (RF_RDA_IN.rd && RF_RDA_IN.dbl) || (RF_RDB_IN.rd && RF_RDB_IN.dbl);
  assign any_sgl = (LINE_VALID_IN && ((TAG_RD_IN.rd && TAG_RD_IN.sgl) || (DAT_RD_IN.rd && DAT_RD_IN.sgl)))
    || (TLB_RD_IN.rd && TLB_RD_IN.sgl) || (RF_RDA_IN.rd && RF_RDA_IN.sgl) || (RF_RDB_IN.rd && RF_RDB_IN.sgl);
  assign any_dbl = ic_dbl || tlb_hw_dbl || tlb_sw_dbl || rf_dbl;

  // Control state
  always_comb
  begin
    next_check_enable_bit = check_enable_bit;
    next_tag_inj = tag_inj;
    next_dat_inj = dat_inj;
    next_tlb_inj = tlb_inj;
    next_rf_inj = rf_inj;
    next_translation_error_flag = translation_error_flag;
    if (cfg_wr)
    begin
      next_check_enable_bit = REG_WDATA_IN[`ECC_CFG_EN_BIT];
    end
    // One corrupted write per arming; a software write the same cycle wins
    if (tag_hit)
    begin
      next_tag_inj = NO_INJECTION_CODE;
    end
    if (dat_hit)
    begin
      next_dat_inj = NO_INJECTION_CODE;
    end
    if (tlb_hit)
    begin
      next_tlb_inj = NO_INJECTION_CODE;
    end
    if (rf_hit)
    begin
      next_rf_inj = NO_INJECTION_CODE;
    end
    if (inj_wr)
    begin
      next_tag_inj = ecc_inj_t'(REG_WDATA_IN[`ECC_INJ_TAG_LSB +: 2]);
      next_dat_inj = ecc_inj_t'(REG_WDATA_IN[`ECC_INJ_DAT_LSB +: 2]);
      next_tlb_inj = ecc_inj_t'(REG_WDATA_IN[`ECC_INJ_TLB_LSB +: 2]);
      next_rf_inj = ecc_inj_t'(REG_WDATA_IN[`ECC_INJ_RF_LSB +: 2]);
    end
    if (misc_wr)
    begin
      next_translation_error_flag = REG_WDATA_IN[`ECC_TRANSLATION_MISC_CONTROL_EE_BIT];
    end
    // Hardware set wins over software clear
    if (check_enable_bit && tlb_sw_dbl)
    begin
      next_translation_error_flag = 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      check_enable_bit <= `ECC_CFG_RST;
      tag_inj <= NO_INJECTION_CODE;
      dat_inj <= NO_INJECTION_CODE;
      tlb_inj <= NO_INJECTION_CODE;
      rf_inj <= NO_INJECTION_CODE;
      translation_error_flag <= 1'b0;
    end
    else
    begin
      check_enable_bit <= next_check_enable_bit;
      tag_inj <= next_tag_inj;
      dat_inj <= next_dat_inj;
      tlb_inj <= next_tlb_inj;
      rf_inj <= next_rf_inj;
      translation_error_flag <= next_translation_error_flag;
    end
  end

  // Register read data, one cycle after the strobe
  always_comb
  begin
    next_rdata = 32'h00000000;
    if (REG_RD_IN)
    begin
      case (REG_ADDR_IN)
        `ECC_CONFIG_OFF: next_rdata[`ECC_CFG_EN_BIT] = check_enable_bit;
        `ECC_INJ_OFF:
        begin
          next_rdata[`ECC_INJ_TAG_LSB +: 2] = tag_inj;
          next_rdata[`ECC_INJ_DAT_LSB +: 2] = dat_inj;
          next_rdata[`ECC_INJ_TLB_LSB +: 2] = tlb_inj;
          next_rdata[`ECC_INJ_RF_LSB +: 2] = rf_inj;
        end
        `ECC_TRANSLATION_MISC_CONTROL_OFF: next_rdata[`ECC_TRANSLATION_MISC_CONTROL_EE_BIT] = translation_error_flag;
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // RAM write path and exception reporting
  ecc_wr_t next_tag_wr;
  ecc_wr_t next_dat_wr;
  ecc_wr_t next_tlb_wr;
  ecc_wr_t next_rf_wr;
  logic next_tag_valid;
  logic next_exc;
  logic [4:0] next_cause;
  ecc_event_t next_event;

  always_comb
  begin
    // Check bits pass through whatever the enable state
    next_tag_wr = corrupt(TAG_WR_IN, tag_hit, tag_inj);
    next_tag_wr.wr = TAG_WR_IN.wr || LINE_INIT_IN;
    next_tag_valid = TAG_VALID_IN && !LINE_INIT_IN;
    next_dat_wr = corrupt(DAT_WR_IN, dat_hit, dat_inj);
    next_tlb_wr = corrupt(TLB_WR_IN, tlb_hit, tlb_inj);
    next_rf_wr = corrupt(RF_WR_IN, rf_hit, rf_inj);
    next_exc = 1'b0;
    next_cause = 5'h00;
    // Single errors corrected silently; priority translation, cache, register
    if (check_enable_bit)
    begin
      if (tlb_hw_dbl)
      begin
        next_exc = 1'b1;
        next_cause = `ECC_CAUSE_TLB;
      end
      else if (ic_dbl)
      begin
        next_exc = 1'b1;
        next_cause = `ECC_CAUSE_ICACHE;
      end
      else if (rf_dbl)
      begin
        next_exc = 1'b1;
        next_cause = `ECC_CAUSE_RF;
      end
    end
    next_event.corrected = check_enable_bit && any_sgl;
    next_event.uncorrected = check_enable_bit && any_dbl;
    next_event.handler_loop = check_enable_bit && any_dbl && IN_HANDLER_IN;
  end

  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      REG_RDATA_OUT <= 32'h00000000;
      TAG_WR_OUT <= '0;
      TAG_VALID_OUT <= 1'b0;
      DAT_WR_OUT <= '0;
      TLB_WR_OUT <= '0;
      RF_WR_OUT <= '0;
      MICRO_TRANSLATION_BUFFER_FLUSH_OUT <= 1'b0;
      TLB_SW_RD_OUT <= 1'b0;
      EXC_OUT <= 1'b0;
      EXC_CAUSE_OUT <= 5'h00;
      EVENT_OUT <= '0;
    end
    else
    begin
      REG_RDATA_OUT <= next_rdata;
      TAG_WR_OUT <= next_tag_wr;
      TAG_VALID_OUT <= next_tag_valid;
      DAT_WR_OUT <= next_dat_wr;
      TLB_WR_OUT <= next_tlb_wr;
      RF_WR_OUT <= next_rf_wr;
      MICRO_TRANSLATION_BUFFER_FLUSH_OUT <= tlb_hit;
      TLB_SW_RD_OUT <= misc_wr && REG_WDATA_IN[`ECC_TRANSLATION_MISC_CONTROL_RD_BIT];
      EXC_OUT <= next_exc;
      EXC_CAUSE_OUT <= next_cause;
      EVENT_OUT <= next_event;
    end
  end

  property p_off_no_exc;
    @(posedge CLK_IN) disable iff (RST_IN) !check_enable_bit |=> !EXC_OUT && !EVENT_OUT.uncorrected;
  endproperty
  a_off_no_exc: assert property (p_off_no_exc) else $error("exception while checking off");

  property p_disable;
    @(posedge CLK_IN) disable iff (RST_IN) cfg_wr && !REG_WDATA_IN[`ECC_CFG_EN_BIT] |=> !check_enable_bit;
  endproperty
  a_disable: assert property (p_disable) else $error("enable not cleared");

  property p_chk_pass;
    @(posedge CLK_IN) disable iff (RST_IN) RF_WR_IN.wr && !rf_hit |=> RF_WR_OUT.chk == $past(RF_WR_IN.chk);
  endproperty
  a_chk_pass: assert property (p_chk_pass) else $error("check bits altered");

  property p_invalid_line;
    @(posedge CLK_IN) disable iff (RST_IN) EXC_OUT && EXC_CAUSE_OUT == `ECC_CAUSE_ICACHE |-> $past(LINE_VALID_IN);
  endproperty
  a_invalid_line: assert property (p_invalid_line) else $error("error on invalid line reported");

  property p_line_init;
    @(posedge CLK_IN) disable iff (RST_IN) LINE_INIT_IN |=> TAG_WR_OUT.wr && !TAG_VALID_OUT;
  endproperty
  a_line_init: assert property (p_line_init) else $error("init did not invalidate line");

  property p_tag_inj;
    @(posedge CLK_IN) disable iff (RST_IN) tag_hit && !inj_wr
      |=> TAG_WR_OUT.chk == ($past(TAG_WR_IN.chk) ^ inj_mask($past(tag_inj))) && tag_inj == NO_INJECTION_CODE;
  endproperty
  a_tag_inj: assert property (p_tag_inj) else $error("tag injection wrong");

  property p_tlb_flush;
    @(posedge CLK_IN) disable iff (RST_IN) tlb_hit |=> MICRO_TRANSLATION_BUFFER_FLUSH_OUT ##1 (!MICRO_TRANSLATION_BUFFER_FLUSH_OUT || $past(tlb_hit));
  endproperty
  a_tlb_flush: assert property (p_tlb_flush) else $error("micro buffer not flushed");

  property p_sw_ee;
    @(posedge CLK_IN) disable iff (RST_IN) check_enable_bit && tlb_sw_dbl |=> translation_error_flag;
  endproperty
  a_sw_ee: assert property (p_sw_ee) else $error("translation error flag not set");

  property p_rf_cause;
    @(posedge CLK_IN) disable iff (RST_IN) check_enable_bit && RF_RDA_IN.rd && RF_RDA_IN.dbl && !tlb_hw_dbl && !ic_dbl
      |=> EXC_OUT && EXC_CAUSE_OUT == `ECC_CAUSE_RF;
  endproperty
  a_rf_cause: assert property (p_rf_cause) else $error("register error not reported");

  property p_loop;
    @(posedge CLK_IN) disable iff (RST_IN) check_enable_bit && any_dbl && IN_HANDLER_IN |=> EVENT_OUT.handler_loop;
  endproperty
  a_loop: assert property (p_loop) else $error("handler loop indicator missing");

endmodule

// *** ecc_regs.svh ***
// Functional notes
// - Checking is off after system reset; no error reported until enabled.
// - Writing 0 to the check enable bit turns checking off.
// - Check bits are always generated and stored, even with checking off.
// - Errors on an invalid instruction cache line are ignored.
// - Cache line init op writes the tag so the line becomes invalid.
// - Only uncorrectable (2 bit) errors raise an exception.
// - Every read of a bad register entry raises a new exception, handler too.
// - Handler loop indicator is driven on the event outputs for outside logic.
// - Armed tag inject field corrupts the tag write at next line fill start.
// - Tag inject field returns to no-injection after the injection.
// - Injected tag error is reported when the jump target is reached.
// - Data inject: first fetch injects, second execution reports.
// - Armed translation inject corrupts next entry write and flushes micro buffer.
// - Translation errors checked on hardware micro buffer reads and software reads.
// - Software translation read error sets the translation error flag.
// - Armed register inject corrupts next write to a non-zero register, then disarms.
// - Reading a corrupted register on source port A raises the exception.
// - Translation error on instruction access records cause 18, general vector.
// - Register file error records cause 20, general vector.
`ifndef ECC_REGS_SVH
`define ECC_REGS_SVH
`define ECC_CONFIG_OFF 4'h0
`define ECC_INJ_OFF 4'h4
`define ECC_TRANSLATION_MISC_CONTROL_OFF 4'h8
`define ECC_CFG_EN_BIT 0
`define ECC_CFG_RST 1'b0
`define ECC_INJ_TAG_LSB 0
`define ECC_INJ_DAT_LSB 2
`define ECC_INJ_TLB_LSB 4
`define ECC_INJ_RF_LSB 6
`define ECC_TRANSLATION_MISC_CONTROL_RD_BIT 0
`define ECC_TRANSLATION_MISC_CONTROL_EE_BIT 1
`define ECC_CHK_W 8
`define ECC_MASK_SINGLE 8'h01
`define ECC_MASK_DOUBLE 8'h03
`define ECC_CAUSE_TLB 5'h12
`define ECC_CAUSE_RF 5'h14
`define ECC_CAUSE_ICACHE 5'h1E
`endif

// *** ecc_pkg.sv ***
`include "ecc_regs.svh"
package ecc_pkg;
  typedef enum logic [1:0] {NO_INJECTION_CODE, INJECT_SINGLE_CODE, INJECT_DOUBLE_CODE, INJECT_RESERVED} ecc_inj_t;
  typedef struct packed
  {
    logic wr;
    logic [`ECC_CHK_W-1:0] chk;
  } ecc_wr_t;
  typedef struct packed
  {
    logic rd;
    logic sgl;
    logic dbl;
  } ecc_rd_t;
  typedef struct packed
  {
    logic corrected;
    logic uncorrected;
    logic handler_loop;
  } ecc_event_t;
endpackage

// *** ecc_loop_mon.sv ***
`timescale 1ns/1ps
module ecc_loop_mon
  import ecc_pkg::*;
#(
  parameter int LOOP_LIMIT = 4
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Watched event bus
  input wire ecc_event_t event_in,
  // Supervisor results
  output logic [7:0] loop_count_out,
  output logic core_rst_req_out
);
  logic [7:0] loop_count;
  logic [7:0] next_loop_count;
  // Count handler loop pulses, ask for a core reset at the limit
  always_comb
  begin
    next_loop_count = loop_count + {7'h00, event_in.handler_loop};
  end
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      loop_count <= 8'h00;
    else
      loop_count <= next_loop_count;
  end
  assign loop_count_out = loop_count;
  assign core_rst_req_out = (loop_count >= LOOP_LIMIT);
endmodule

// *** test_processor_ecc_control_and_injection.sv ***
`timescale 1ns/1ps
`include "ecc_regs.svh"
module test_processor_ecc_control_and_injection
  import ecc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  ecc_wr_t wi [4];
  ecc_wr_t wo [4];
  logic tag_v;
  logic linit;
  logic dfirst;
  logic [4:0] idx;
  ecc_rd_t rds [5];
  logic lv;
  logic sw;
  logic hnd;
  logic tag_vo;
  logic flush;
  logic swrd;
  logic exc;
  logic [4:0] cause;
  ecc_event_t ev;
  logic [7:0] loop_count;
  logic en = 1'b0;
  int fail_count = 0;
  int n_tests = 0;
  int exp_loops = 0;
  int cycles = 0;
  logic [7:0] r;
  ecc_rd_t v;

  ecc_ctrl uut (.CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .TAG_WR_IN(wi[0]), .TAG_VALID_IN(tag_v), .LINE_INIT_IN(linit),
    .DAT_WR_IN(wi[1]), .DAT_FIRST_IN(dfirst), .TLB_WR_IN(wi[2]), .RF_WR_IN(wi[3]), .RF_WR_IDX_IN(idx),
    .TAG_WR_OUT(wo[0]), .TAG_VALID_OUT(tag_vo), .DAT_WR_OUT(wo[1]), .TLB_WR_OUT(wo[2]), .RF_WR_OUT(wo[3]),
    .MICRO_TRANSLATION_BUFFER_FLUSH_OUT(flush), .TAG_RD_IN(rds[0]), .DAT_RD_IN(rds[1]), .LINE_VALID_IN(lv), .TLB_RD_IN(rds[2]),
    .TLB_RD_SW_IN(sw), .RF_RDA_IN(rds[3]), .RF_RDB_IN(rds[4]), .IN_HANDLER_IN(hnd), .TLB_SW_RD_OUT(swrd),
    .EXC_OUT(exc), .EXC_CAUSE_OUT(cause), .EVENT_OUT(ev));
  ecc_loop_mon mon (.clk_in(clk), .rst_in(rst), .event_in(ev), .loop_count_out(loop_count),
    .core_rst_req_out());

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  task stop_test;
    if (fail_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      stop_test;
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task clr;
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= 4'h0;
    wdata <= 32'h0;
    wi <= '{default: '0};
    rds <= '{default: '0};
    tag_v <= 1'b0;
    linit <= 1'b0;
    dfirst <= 1'b0;
    idx <= 5'h00;
    lv <= 1'b0;
    sw <= 1'b0;
    hnd <= 1'b0;
  endtask

  // One edge for the request, then look after the outputs settle
  task cyc;
    @(posedge clk);
    clr;
    #1;
  endtask

  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    cyc;
    if (a == `ECC_CONFIG_OFF)
      en = d[`ECC_CFG_EN_BIT];
  endtask

  task rreg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    cyc;
    check(rdata, e);
  endtask

  function automatic logic [7:0] mask_of(input int c);
    return (c == 1) ? `ECC_MASK_SINGLE : (c == 2) ? `ECC_MASK_DOUBLE : 8'h00;
  endfunction

  function automatic logic [8:0] exp_rd(input int p, input ecc_rd_t x, input logic l, input logic h);
    if (!en || !x.rd || (p < 2 && !l))
      return 9'h000;
    if (x.dbl)
      return {1'b1, (p == 2) ? `ECC_CAUSE_TLB : (p < 2) ? `ECC_CAUSE_ICACHE : `ECC_CAUSE_RF, 2'b01, h};
    return {6'h00, x.sgl, 2'b00};
  endfunction

  task automatic wram(input int f, input logic [7:0] d, input logic [4:0] i, input logic [7:0] e);
    @(posedge clk);
    wi[f] <= '{1'b1, d};
    tag_v <= 1'b1;
    dfirst <= 1'b1;
    idx <= i;
    cyc;
    check(wo[f], {1'b1, e});
  endtask

  task automatic rd_chk(input int p, input ecc_rd_t x, input logic l, input logic h);
    logic [8:0] e;
    e = exp_rd(p, x, l, h);
    exp_loops += e[0];
    @(posedge clk);
    rds[p] <= x;
    lv <= l;
    hnd <= h;
    cyc;
    check({exc, cause, ev}, e);
  endtask

  initial
  begin
    clr;
    void'($urandom(23));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    check({exc, cause, ev, tag_vo, flush, swrd}, 32'h0);
    rreg(`ECC_CONFIG_OFF, 32'h0);
    rd_chk(3, '{1'b1, 1'b0, 1'b1}, 1'b1, 1'b0);
    wreg(`ECC_CONFIG_OFF, 32'h1);
    rreg(`ECC_CONFIG_OFF, 32'h1);
    rreg(4'hC, 32'h0);
    for (int p = 0; p < 5; p++)
      rd_chk(p, '{1'b1, 1'b0, 1'b1}, 1'b1, 1'b0);
    rd_chk(3, '{1'b1, 1'b0, 1'b1}, 1'b1, 1'b1);
    rd_chk(3, '{1'b1, 1'b0, 1'b1}, 1'b1, 1'b1);
    rd_chk(0, '{1'b1, 1'b0, 1'b1}, 1'b0, 1'b0);
    rd_chk(3, '{1'b1, 1'b1, 1'b0}, 1'b1, 1'b0);
    @(posedge clk);
    rds[2] <= '{1'b1, 1'b0, 1'b1};
    sw <= 1'b1;
    cyc;
    check(exc, 1'b0);
    rreg(`ECC_TRANSLATION_MISC_CONTROL_OFF, 32'h2);
    wreg(`ECC_TRANSLATION_MISC_CONTROL_OFF, 32'h1);
    check(swrd, 1'b1);
    @(posedge clk);
    wi[0] <= '{1'b1, 8'h5A};
    tag_v <= 1'b1;
    linit <= 1'b1;
    cyc;
    check({wo[0].wr, tag_vo}, 2'b10);
    repeat (30)
    begin
      v = '{1'b1, 1'b0, 1'b0};
      v.sgl = ($urandom_range(2) == 1);
      v.dbl = !v.sgl && $urandom_range(1);
      rd_chk($urandom_range(4), v, $urandom_range(1), $urandom_range(1));
    end
    for (int f = 0; f < 4; f++)
      // Code 3 is reserved: never corrupts and is never cleared by hardware
      for (int c = 0; c < 4; c++)
      begin
        r = $urandom;
        wreg(`ECC_INJ_OFF, c << (2 * f));
        if (f == 3)
          wram(f, r, 5'h00, r);
        wram(f, r, $urandom_range(31, 1), r ^ mask_of(c));
        check(flush, f == 2 && (c == 1 || c == 2));
        check(tag_vo, 1'b1);
        rreg(`ECC_INJ_OFF, (c == 3) ? (c << (2 * f)) : 32'h0);
        wram(f, r, 5'h01, r);
      end
    wreg(`ECC_CONFIG_OFF, 32'h0);
    rd_chk(3, '{1'b1, 1'b0, 1'b1}, 1'b1, 1'b1);
    wram(3, 8'hC3, 5'h02, 8'hC3);
    check(loop_count, exp_loops);
    stop_test;
  end
endmodule
